// File: pmc_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Reset always lands in normal run
// - Wait-for-interrupt enters wait or stop
// - Each run mode has own wait, stop
// - Pin states held in every mode
// - Normal wait: peripherals clocked, interrupt wakes
// - Normal stop: clocks off, detect on, async wake
// - Low power run: low regulator, slow flash
// - Low power wait: sleep flagged, core clock kept on, interrupts wake
// - Low power stop: core, peripheral clocks off
// - Timer and UART in low power stop only if enabled, clocked
// - SRAM retained in low power, leakage stop
// - Leakage stop: retention, wake unit interrupt
// - Level three: peripherals off, wake reset
// - Level three keeps both SRAM halves
// - Wake interrupt resumes run via service
// - Wake reset leaves wake flag pending
module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Software controls
  input wire logic i_vlp_run_req,
  input wire logic [2:0] i_target_sel,
  input wire logic i_target_wr,
  input wire logic i_tpm_en,
  input wire logic i_tpm_clk_en,
  input wire logic i_uart_en,
  input wire logic i_uart_clk_en,
  // Core
  input wire logic i_wfi,
  // Wake sources, asynchronous
  input wire logic i_irq,
  input wire logic i_wake_pin,
  // Clock and power controls
  output logic o_core_clk_en,
  output logic o_periph_clk_en,
  output logic o_reg_low_power,
  output logic o_flash_slow,
  output logic o_lvd_en,
  output logic o_nested_interrupt_controller_en,
  output logic o_async_wakeup_irq_unit_en,
  output logic o_low_leakage_wakeup_unit_en,
  output logic o_periph_retain,
  output logic o_tpm_run,
  output logic o_uart_run,
  output logic o_sram_retain,
  output logic o_io_hold,
  output logic o_sleep,
  output logic o_sleep_deep,
  output logic o_low_leakage_wakeup_unit_irq_pend,
  output logic o_wake_reset,
  output logic [8:0] o_mode
);
  pmc_state_t state_q;
  pmc_state_t state_d;
  pmc_sel_t sel_q;
  logic irq_s;
  logic pin_s;
  logic wake_any;
  logic vlp_q;
  logic [3:0] wrst_cnt_q;
  logic pend_q;

  // Wake sources come from other domains
  pmc_sync #(.WIDTH(2)) u_sync
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_irq, i_wake_pin}),
    .o_sync({irq_s, pin_s})
  );
  assign wake_any = irq_s | pin_s;

  // Target latched at write, used on wait-for-interrupt
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      sel_q <= PMC_SEL_WAIT;
    else if (i_target_wr)
      sel_q <= pmc_sel_t'(i_target_sel);
  end

  // Run-mode flavour request, registered every cycle, used only in run states
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      vlp_q <= 1'b0;
    else
      vlp_q <= i_vlp_run_req;
  end

  // Mode transitions
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PMC_ST_RUN, PMC_ST_VERY_LOW_POWER_RUN:
      begin
        if (i_wfi)
        begin
          // each run mode picks its own wait or stop
          if (sel_q == PMC_SEL_WAIT)
            state_d = (state_q == PMC_ST_RUN) ? PMC_ST_WAIT : PMC_ST_VERY_LOW_POWER_WAIT;
          else if (sel_q == PMC_SEL_STOP)
            state_d = (state_q == PMC_ST_RUN) ? PMC_ST_STOP : PMC_ST_VERY_LOW_POWER_STOP;
          else if (sel_q == PMC_SEL_LLS)
            state_d = PMC_ST_LLS;
          else
            state_d = PMC_ST_LS3;
        end
        else
          state_d = vlp_q ? PMC_ST_VERY_LOW_POWER_RUN : PMC_ST_RUN;
      end
      PMC_ST_WAIT, PMC_ST_STOP:
      begin
        if (irq_s)
          state_d = PMC_ST_RUN;
      end
      PMC_ST_VERY_LOW_POWER_WAIT, PMC_ST_VERY_LOW_POWER_STOP:
      begin
        if (irq_s)
          state_d = PMC_ST_VERY_LOW_POWER_RUN;
      end
      PMC_ST_LLS:
      begin
        if (wake_any)
          state_d = PMC_ST_RUN;
      end
      PMC_ST_LS3:
      begin
        if (wake_any)
          state_d = PMC_ST_WRST;
      end
      PMC_ST_WRST:
      begin
        if (wrst_cnt_q == PMC_WRST_CYCLES)
          state_d = PMC_ST_RUN;
      end
      default: state_d = PMC_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      state_q <= PMC_ST_RUN;
    else
      state_q <= state_d;
  end

  // Wake-reset pulse counter
  always_ff @(posedge i_clk)
  begin
    if (i_reset || state_q != PMC_ST_WRST)
      wrst_cnt_q <= 4'h0;
    else
      wrst_cnt_q <= wrst_cnt_q + 4'h1;
  end

  // Wake flag set on leakage wake; sticky, since this block has no clear input
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      pend_q <= 1'b0;
    else if ((state_q == PMC_ST_LLS || state_q == PMC_ST_LS3) && wake_any)
      pend_q <= 1'b1;
  end

  // Output decode per mode
  always_comb
  begin
    o_core_clk_en = state_q inside {PMC_ST_RUN, PMC_ST_VERY_LOW_POWER_RUN, PMC_ST_VERY_LOW_POWER_WAIT};
    o_periph_clk_en = state_q inside {PMC_ST_RUN, PMC_ST_VERY_LOW_POWER_RUN, PMC_ST_WAIT,
                                      PMC_ST_VERY_LOW_POWER_WAIT};
    o_reg_low_power = (state_q inside {PMC_ST_VERY_LOW_POWER_RUN, PMC_ST_VERY_LOW_POWER_WAIT, PMC_ST_VERY_LOW_POWER_STOP})
                      ? PMC_REG_LOW : PMC_REG_FULL;
    o_flash_slow = (state_q inside {PMC_ST_VERY_LOW_POWER_RUN, PMC_ST_VERY_LOW_POWER_WAIT})
                   ? PMC_FLASH_SLOW : PMC_FLASH_FULL;
    o_lvd_en = state_q inside {PMC_ST_RUN, PMC_ST_WAIT, PMC_ST_STOP, PMC_ST_WRST};
    o_nested_interrupt_controller_en = state_q inside {PMC_ST_RUN, PMC_ST_WAIT, PMC_ST_VERY_LOW_POWER_RUN,
                                PMC_ST_VERY_LOW_POWER_WAIT, PMC_ST_WRST};
    o_async_wakeup_irq_unit_en = state_q inside {PMC_ST_STOP, PMC_ST_VERY_LOW_POWER_STOP};
    o_low_leakage_wakeup_unit_en = state_q inside {PMC_ST_LLS, PMC_ST_LS3};
    o_periph_retain = state_q == PMC_ST_LLS;
    o_tpm_run = o_periph_clk_en ||
                (state_q == PMC_ST_VERY_LOW_POWER_STOP && i_tpm_en && i_tpm_clk_en);
    o_uart_run = o_periph_clk_en ||
                 (state_q == PMC_ST_VERY_LOW_POWER_STOP && i_uart_en && i_uart_clk_en);
    o_sram_retain = 1'b1;
    o_io_hold = 1'b1;
    o_sleep = state_q inside {PMC_ST_WAIT, PMC_ST_VERY_LOW_POWER_WAIT};
    o_sleep_deep = state_q inside {PMC_ST_STOP, PMC_ST_VERY_LOW_POWER_STOP, PMC_ST_LLS, PMC_ST_LS3};
    o_wake_reset = state_q == PMC_ST_WRST;
    o_low_leakage_wakeup_unit_irq_pend = pend_q;
    o_mode = state_q;
  end

  // Assertions
  a_reset_to_run: assert property (@(posedge i_clk)
    i_reset |=> state_q == PMC_ST_RUN) else $error("not run after reset");
  a_wfi_enters_wait: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_RUN && i_wfi && sel_q == PMC_SEL_WAIT |=> state_q == PMC_ST_WAIT)
    else $error("wait not entered");
  a_vlp_own_stop: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_VERY_LOW_POWER_RUN && i_wfi && sel_q == PMC_SEL_STOP |=> state_q == PMC_ST_VERY_LOW_POWER_STOP)
    else $error("wrong stop variant");
  a_wait_irq_wake: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_WAIT && irq_s |=> state_q == PMC_ST_RUN && o_core_clk_en)
    else $error("wait did not wake");
  a_stop_clocks: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_STOP |-> !o_periph_clk_en && o_lvd_en && o_async_wakeup_irq_unit_en && !o_nested_interrupt_controller_en)
    else $error("stop controls wrong");
  a_very_low_power_run_power: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_VERY_LOW_POWER_RUN |-> o_reg_low_power && o_flash_slow && !o_lvd_en)
    else $error("low power run wrong");
  a_very_low_power_stop_tpm_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == PMC_ST_VERY_LOW_POWER_STOP |-> o_tpm_run == (i_tpm_en && i_tpm_clk_en))
    else $error("timer gating wrong");
  sequence s_ls3_wake;
    state_q == PMC_ST_LS3 && wake_any ##1 state_q == PMC_ST_WRST;
  endsequence
  a_ls3_wake_reset: assert property (@(posedge i_clk) disable iff (i_reset)
    s_ls3_wake |-> o_wake_reset [*5] ##1 state_q == PMC_ST_RUN && o_low_leakage_wakeup_unit_irq_pend)
    else $error("wake reset flow wrong");
  a_io_hold: assert property (@(posedge i_clk) o_io_hold && o_sram_retain)
    else $error("pins or sram not held");
endmodule // pmc_ctrl

// File: pmc_pkg.sv
package pmc_pkg;

  // Software-selected target for the next wait-for-interrupt
  typedef enum logic [2:0]
  {
    PMC_SEL_WAIT = 3'h0,
    PMC_SEL_STOP = 3'h1,
    PMC_SEL_LLS = 3'h2,
    PMC_SEL_LS3 = 3'h3
  } pmc_sel_t;

  // Controller states, one-hot
  typedef enum logic [8:0]
  {
    PMC_ST_RUN = 9'h001,
    PMC_ST_WAIT = 9'h002,
    PMC_ST_STOP = 9'h004,
    PMC_ST_VERY_LOW_POWER_RUN = 9'h008,
    PMC_ST_VERY_LOW_POWER_WAIT = 9'h010,
    PMC_ST_VERY_LOW_POWER_STOP = 9'h020,
    PMC_ST_LLS = 9'h040,
    PMC_ST_LS3 = 9'h080,
    PMC_ST_WRST = 9'h100
  } pmc_state_t;

  // Regulator / flash speed encodings
  localparam logic PMC_REG_FULL = 1'b0;
  localparam logic PMC_REG_LOW = 1'b1;
  localparam logic PMC_FLASH_FULL = 1'b0;
  localparam logic PMC_FLASH_SLOW = 1'b1;

  // Wake-up reset pulse length in clock cycles, minus one
  localparam logic [3:0] PMC_WRST_CYCLES = 4'h4;

endpackage

// File: pmc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous wake levels
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // pmc_sync

// File: pmc_core_model.sv
`timescale 1ns/1ps
// Core issuing the sleep instruction and the wake sources beside it
module pmc_core_model
(
  // Clock
  input wire logic i_clk,
  // Bench commands
  input wire logic i_go_wfi,
  input wire logic [1:0] i_go_wake,
  input wire logic i_awake,
  // Toward the controller
  output logic o_wfi,
  output logic o_irq,
  output logic o_wake_pin
);
  initial
  begin
    o_wfi = 1'b0;
    o_irq = 1'b0;
    o_wake_pin = 1'b0;
  end

  // Wake levels stay up until the chip runs again, like an unserviced source
  always @(negedge i_clk)
  begin
    o_wfi <= i_go_wfi;
    if (i_go_wake[0])
      o_irq <= 1'b1;
    else if (i_awake)
      o_irq <= 1'b0;
    if (i_go_wake[1])
      o_wake_pin <= 1'b1;
    else if (i_awake)
      o_wake_pin <= 1'b0;
  end
endmodule // pmc_core_model

// File: pmc_ctrl_bench.sv
`timescale 1ns/1ps
module pmc_ctrl_bench;
  import pmc_pkg::*;
  logic i_clk, i_reset, i_vlp_run_req, i_target_wr, i_tpm_en, i_tpm_clk_en;
  logic i_uart_en, i_uart_clk_en, go_wfi, pend_exp, wait_for_interrupt_instruction, irq, pin;
  logic [2:0] i_target_sel;
  logic [1:0] go_wake;
  logic o_core_clk_en, o_periph_clk_en, o_reg_low_power, o_flash_slow, o_lvd_en, o_nested_interrupt_controller_en;
  logic o_tpm_run, o_uart_run, o_sram_retain, o_io_hold, o_sleep_deep, o_low_leakage_wakeup_unit_irq_pend;
  logic o_wake_reset, o_sleep, o_async_wakeup_irq_unit_en, o_low_leakage_wakeup_unit_en, o_periph_retain;
  logic [8:0] o_mode;
  logic [31:0] rs = 32'h0000_0040;
  int checks = 0;
  int err_count = 0;
  wire logic awake = (o_mode === PMC_ST_RUN) || (o_mode === PMC_ST_VERY_LOW_POWER_RUN);

  pmc_ctrl u_pmc_ctrl (.i_clk(i_clk), .i_reset(i_reset), .i_vlp_run_req(i_vlp_run_req),
    .i_target_sel(i_target_sel), .i_target_wr(i_target_wr), .i_tpm_en(i_tpm_en),
    .i_tpm_clk_en(i_tpm_clk_en), .i_uart_en(i_uart_en), .i_uart_clk_en(i_uart_clk_en),
    .i_wfi(wait_for_interrupt_instruction), .i_irq(irq), .i_wake_pin(pin), .o_core_clk_en(o_core_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_reg_low_power(o_reg_low_power),
    .o_flash_slow(o_flash_slow), .o_lvd_en(o_lvd_en), .o_nested_interrupt_controller_en(o_nested_interrupt_controller_en),
    .o_async_wakeup_irq_unit_en(o_async_wakeup_irq_unit_en), .o_low_leakage_wakeup_unit_en(o_low_leakage_wakeup_unit_en), .o_periph_retain(o_periph_retain),
    .o_tpm_run(o_tpm_run), .o_uart_run(o_uart_run),
    .o_sram_retain(o_sram_retain), .o_io_hold(o_io_hold), .o_sleep(o_sleep),
    .o_sleep_deep(o_sleep_deep), .o_low_leakage_wakeup_unit_irq_pend(o_low_leakage_wakeup_unit_irq_pend),
    .o_wake_reset(o_wake_reset), .o_mode(o_mode));

  pmc_core_model u_pmc_core_model (.i_clk(i_clk), .i_go_wfi(go_wfi), .i_go_wake(go_wake),
    .i_awake(awake), .o_wfi(wait_for_interrupt_instruction), .o_irq(irq), .o_wake_pin(pin));

  // Clock, 5 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [8:0] exp_mode(input logic v, input logic [1:0] s);
    case (s)
      2'h0: return v ? PMC_ST_VERY_LOW_POWER_WAIT : PMC_ST_WAIT;
      2'h1: return v ? PMC_ST_VERY_LOW_POWER_STOP : PMC_ST_STOP;
      2'h2: return PMC_ST_LLS;
      default: return PMC_ST_LS3;
    endcase
  endfunction

  // Care mask in the high byte; only controls the mode fixes are compared
  function automatic logic [15:0] exp_out(input logic [8:0] m);
    case (m)
      PMC_ST_RUN: return 16'hFFCD;
      PMC_ST_WAIT: return 16'h7F4D;
      PMC_ST_STOP: return 16'h4F0B;
      PMC_ST_VERY_LOW_POWER_RUN, PMC_ST_VERY_LOW_POWER_WAIT: return 16'hFFF5;
      PMC_ST_VERY_LOW_POWER_STOP: return 16'hEF23;
      default: return 16'h0703;
    endcase
  endfunction

  // Sleep, async wake, leakage wake unit and retention per mode
  function automatic logic [3:0] exp_aux(input logic [8:0] m);
    case (m)
      PMC_ST_WAIT, PMC_ST_VERY_LOW_POWER_WAIT: return 4'h8;
      PMC_ST_STOP, PMC_ST_VERY_LOW_POWER_STOP: return 4'h4;
      PMC_ST_LLS: return 4'h3;
      PMC_ST_LS3: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction

  task automatic results();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask

  task automatic chk_out(input logic [8:0] m);
    logic [15:0] e;
    logic [7:0] g;
    e = exp_out(m);
    g = {o_core_clk_en, o_periph_clk_en, o_reg_low_power, o_flash_slow, o_lvd_en, o_nested_interrupt_controller_en,
      o_sleep_deep, o_sram_retain};
    chk({1'b0, g & e[15:8]}, {1'b0, e[7:0] & e[15:8]});
    chk({8'h00, o_io_hold}, 9'h001);
    chk({5'h00, o_sleep, o_async_wakeup_irq_unit_en, o_low_leakage_wakeup_unit_en, o_periph_retain}, {5'h00, exp_aux(m)});
  endtask

  // Bounded wait; a run-out ends the test
  task automatic wait_mode(input logic [8:0] m);
    int n;
    n = 0;
    while (o_mode !== m && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(o_mode, m);
    if (n == 50)
      results();
  endtask

  task automatic pulse_wfi(input logic [8:0] m);
    go_wfi <= 1'b1;
    @(negedge i_clk);
    go_wfi <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_mode, m);
  endtask

  task automatic run_one(input logic v, input logic [1:0] s);
    logic [8:0] rm, sm;
    logic [31:0] r;
    int n;
    r = rnd();
    rm = v ? PMC_ST_VERY_LOW_POWER_RUN : PMC_ST_RUN;
    sm = exp_mode(v, s);
    i_vlp_run_req = v;
    wait_mode(rm);
    repeat (3 + r[1:0]) @(negedge i_clk);
    chk_out(rm);
    i_target_sel = {1'b0, s};
    i_target_wr = 1'b1;
    @(negedge i_clk);
    // Selector moves after the latch; the latched target must win
    i_target_wr = 1'b0;
    i_target_sel = {1'b0, r[3:2]};
    {i_tpm_en, i_tpm_clk_en, i_uart_en, i_uart_clk_en} = r[7:4];
    pulse_wfi(sm);
    chk_out(sm);
    if (sm == PMC_ST_VERY_LOW_POWER_STOP)
      chk({7'h00, o_tpm_run, o_uart_run}, {7'h00, r[7] & r[6], r[5] & r[4]});
    pulse_wfi(sm);
    repeat (r[10:9]) @(negedge i_clk);
    if (s[1])
      i_vlp_run_req = 1'b0;
    go_wake <= (s[1] & r[8]) ? 2'b10 : 2'b01;
    @(negedge i_clk);
    go_wake <= 2'b00;
    if (s == 2'h3)
    begin
      wait_mode(PMC_ST_WRST);
      n = 0;
      while (o_wake_reset === 1'b1 && n < 20)
      begin
        @(negedge i_clk);
        n++;
      end
      chk(n[8:0], {5'h00, PMC_WRST_CYCLES} + 9'h001);
    end
    wait_mode(s[1] ? PMC_ST_RUN : rm);
    pend_exp = pend_exp | s[1]; // Both leakage wakes leave the flag pending
    chk({8'h00, o_low_leakage_wakeup_unit_irq_pend}, {8'h00, pend_exp});
  endtask

  initial
  begin
    {i_reset, i_vlp_run_req, i_target_wr, i_tpm_en, i_tpm_clk_en} = 5'b10000;
    {i_uart_en, i_uart_clk_en, go_wfi, pend_exp} = 4'h0;
    i_target_sel = 3'h0;
    go_wake = 2'b00;
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    @(negedge i_clk);
    chk(o_mode, PMC_ST_RUN);
    for (int k = 0; k < 16; k++)
      run_one(k[2], k[1:0]);
    // Reset in the middle of low power run
    i_vlp_run_req = 1'b1;
    wait_mode(PMC_ST_VERY_LOW_POWER_RUN);
    i_reset = 1'b1;
    @(negedge i_clk);
    i_reset = 1'b0;
    chk(o_mode, PMC_ST_RUN);
    chk({8'h00, o_low_leakage_wakeup_unit_irq_pend}, 9'h000);
    results();
  end
endmodule // pmc_ctrl_bench
